// ==== bench/prqw_rc_model.sv ====
// Purpose: Root complex side model that delivers page request messages
// Assumes: Messages are launched right after a rising edge, one per cycle
// Notes: Released message fields show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module prqw_rc_model (
  input wire logic clk,
  output logic msg_valid,
  output logic [15:0] msg_requester_id,
  output logic [15:0] msg_rc_id,
  output logic msg_pasid_present,
  output logic [19:0] msg_pasid,
  output logic msg_last,
  output logic msg_write,
  output logic msg_read,
  output logic msg_exec,
  output logic msg_priv,
  output logic [8:0] msg_group_index,
  output logic [51:0] msg_page_addr
);
  // Idle at time zero
  initial begin
    msg_valid = 1'b0;
    {msg_requester_id, msg_rc_id, msg_pasid_present, msg_pasid, msg_last, msg_write,
      msg_read, msg_exec, msg_priv, msg_group_index, msg_page_addr} = '0;
  end

  // Sends n back to back requests of one group; last flag only on the final one
  task automatic send(input logic [15:0] rid, input logic [15:0] rc, input logic pp,
    input logic [19:0] pasid, input logic [2:0] last_write_read_code, input logic [1:0] xp,
    input logic [8:0] grp, input logic [51:0] pa, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      msg_valid <= 1'b1;
      msg_requester_id <= rid;
      msg_rc_id <= rc;
      msg_pasid_present <= pp;
      msg_pasid <= pasid;
      msg_last <= (i == n - 1) ? last_write_read_code[2] : 1'b0;
      {msg_write, msg_read, msg_exec, msg_priv} <= {last_write_read_code[1:0], xp};
      msg_group_index <= grp;
      msg_page_addr <= pa + 52'(i);
    end
    @(posedge clk);
    msg_valid <= 1'b0;
    // Released lines do not keep the last value
    {msg_requester_id, msg_rc_id, msg_pasid_present, msg_pasid, msg_last, msg_write,
      msg_read, msg_exec, msg_priv, msg_group_index, msg_page_addr} <=
      ~{msg_requester_id, msg_rc_id, msg_pasid_present, msg_pasid, msg_last, msg_write,
      msg_read, msg_exec, msg_priv, msg_group_index, msg_page_addr};
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the page request queue writer
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Expected records are built here from the field layout
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import prqw_pkg::*;
  logic clk, rst, reg_wr, reg_rd, msg_valid, msg_pasid_present, msg_last, msg_write;
  logic msg_read, msg_exec, msg_priv, mem_wr_valid, last_req_pulse, resp_valid;
  logic resp_success, resp_pasid_present;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] msg_requester_id, msg_rc_id, resp_requester_id;
  logic [19:0] msg_pasid, resp_pasid;
  logic [8:0] msg_group_index, resp_group_index;
  logic [51:0] msg_page_addr;
  logic [63:0] mem_wr_addr, last_addr;
  logic [PRQW_REC_W-1:0] mem_wr_data, last_data;
  int errors = 0, total_checks = 0, wr_cnt = 0, pulse_cnt = 0;

  prqw_top u_prqw_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_valid(msg_valid),
    .msg_requester_id(msg_requester_id), .msg_rc_id(msg_rc_id),
    .msg_pasid_present(msg_pasid_present), .msg_pasid(msg_pasid), .msg_last(msg_last),
    .msg_write(msg_write), .msg_read(msg_read), .msg_exec(msg_exec), .msg_priv(msg_priv),
    .msg_group_index(msg_group_index), .msg_page_addr(msg_page_addr),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .last_req_pulse(last_req_pulse), .resp_valid(resp_valid),
    .resp_requester_id(resp_requester_id), .resp_group_index(resp_group_index),
    .resp_success(resp_success), .resp_pasid_present(resp_pasid_present),
    .resp_pasid(resp_pasid));
  prqw_rc_model u_prqw_rc_model (.clk(clk), .msg_valid(msg_valid),
    .msg_requester_id(msg_requester_id), .msg_rc_id(msg_rc_id),
    .msg_pasid_present(msg_pasid_present), .msg_pasid(msg_pasid), .msg_last(msg_last),
    .msg_write(msg_write), .msg_read(msg_read), .msg_exec(msg_exec), .msg_priv(msg_priv),
    .msg_group_index(msg_group_index), .msg_page_addr(msg_page_addr));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Memory side: takes every write, keeps the latest one
  always @(posedge clk) begin
    if (mem_wr_valid === 1'b1) begin
      wr_cnt++;
      last_data = mem_wr_data;
      last_addr = mem_wr_addr;
    end
    if (last_req_pulse === 1'b1) pulse_cnt++;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // Expected record; lwrxp is last, write, read, execute, supervisor
  function automatic logic [127:0] rec_of(logic [31:0] src, logic substream_valid_flag, logic [19:0] tag,
    logic [4:0] lwrxp, logic [8:0] g, logic [51:0] pa);
    logic [127:0] r;
    r = '0;
    r[31:0] = src;
    r[51:32] = substream_valid_flag ? tag : 20'h0_0000;
    r[62:58] = {lwrxp[4:2], substream_valid_flag ? lwrxp[1:0] : 2'b00};
    r[63] = substream_valid_flag;
    r[72:64] = g;
    r[127:76] = pa;
    return r;
  endfunction

  // Context tag is unspecified while substream valid is low
  task automatic check_rec(input logic [127:0] exp, input logic [63:0] addr);
    logic [127:0] seen;
    seen = last_data;
    if (seen[63] === 1'b0) seen[51:32] = 20'h0_0000;
    check(seen, exp);
    check(last_addr, addr);
  endtask

  task automatic t_regs();
    reg_check(PRQW_OFF_CTRL, 32'h0000_0000);
    reg_check(PRQW_OFF_LOG2, 32'h0000_0004);
    reg_check(PRQW_OFF_STATUS, 32'h0000_0004);
    reg_write(PRQW_OFF_PROD, 32'h0000_0005);
    reg_check(PRQW_OFF_PROD, 32'h0000_0000);
    reg_check(8'h24, 32'h0000_0000);
    reg_write(PRQW_OFF_LOG2, 32'h0000_001f);
    reg_check(PRQW_OFF_LOG2, 32'h0000_0013);
    reg_write(PRQW_OFF_LOG2, 32'h0000_0004);
    $display("test regs done");
  endtask

  // A whole group with a prefix, last pulse enabled
  task automatic t_group();
    int w0, p0;
    reg_write(PRQW_OFF_CTRL, 32'h0000_0007);
    reg_write(PRQW_OFF_BASE_LO, 32'h0000_1000);
    reg_write(PRQW_OFF_BASE_HI, 32'h0000_0001);
    w0 = wr_cnt;
    p0 = pulse_cnt;
    u_prqw_rc_model.send(16'hbeef, 16'h0003, 1'b1, 20'hcafe5, 3'b111, 2'b11, 9'h105,
      52'h0_1234_5678_9ab0, 3);
    repeat (3) @(posedge clk);
    #1 check(wr_cnt - w0, 3);
    check(pulse_cnt - p0, 1);
    check_rec(rec_of(32'h0003_beef, 1'b1, 20'hcafe5, 5'b11111, 9'h105,
      52'h0_1234_5678_9ab2), 64'h0000_0001_0000_1020);
    $display("test group done");
  endtask

  // One single message and the record it must leave
  task automatic one(input logic pp, input logic [2:0] last_write_read_code, input logic substream_valid_flag,
    input int dp, input logic [63:0] ea);
    int p0;
    p0 = pulse_cnt;
    u_prqw_rc_model.send(16'h0042, 16'h0000, pp, 20'h5a5a5, last_write_read_code, 2'b11, 9'h01a,
      52'h0_0000_0000_0777, 1);
    repeat (3) @(posedge clk);
    #1 check(pulse_cnt - p0, dp);
    check_rec(rec_of(32'h0000_0042, substream_valid_flag, 20'h5a5a5, {last_write_read_code, substream_valid_flag ? 2'b11 : 2'b00}, 9'h01a,
      52'h0_0000_0000_0777), ea);
  endtask

  task automatic t_codes();
    int w0;
    one(1'b0, PRQW_LWR_STOP, 1'b0, 1, 64'h0000_0001_0000_1030);
    one(1'b1, PRQW_LWR_STOP, 1'b1, 0, 64'h0000_0001_0000_1040);
    reg_write(PRQW_OFF_CTRL, 32'h0000_0005);
    one(1'b1, 3'b011, 1'b0, 0, 64'h0000_0001_0000_1050);
    reg_write(PRQW_OFF_CTRL, 32'h0000_0000);
    w0 = wr_cnt;
    u_prqw_rc_model.send(16'h0001, 16'h0000, 1'b0, 20'h0_0000, 3'b011, 2'b00, 9'h000,
      52'h0_0000_0000_0001, 2);
    repeat (3) @(posedge clk);
    #1 check(wr_cnt - w0, 0);
    $display("test codes done");
  endtask

  // Fill the 16-entry ring, overflow, consume, acknowledge
  task automatic t_overflow();
    int w0;
    do_reset();
    reg_write(PRQW_OFF_CTRL, 32'h0000_0001);
    w0 = wr_cnt;
    u_prqw_rc_model.send(16'h0007, 16'h0000, 1'b0, 20'h0_0000, 3'b011, 2'b00, 9'h002,
      52'h0_0000_0000_0100, 16);
    repeat (3) @(posedge clk);
    #1 check(wr_cnt - w0, 16);
    reg_check(PRQW_OFF_STATUS, 32'h0000_0003);
    u_prqw_rc_model.send(16'h0007, 16'h0000, 1'b0, 20'h0_0000, 3'b111, 2'b00, 9'h002,
      52'h0_0000_0000_0200, 1);
    reg_check(PRQW_OFF_PROD, 32'h8000_0010);
    reg_check(PRQW_OFF_STATUS, 32'h0000_000b);
    reg_write(PRQW_OFF_CONS, 32'h0000_0010);
    u_prqw_rc_model.send(16'h0007, 16'h0000, 1'b0, 20'h0_0000, 3'b011, 2'b00, 9'h003,
      52'h0_0000_0000_0300, 1);
    repeat (3) @(posedge clk);
    #1 check(wr_cnt - w0, 16);
    reg_write(PRQW_OFF_CONS, 32'h8000_0010);
    u_prqw_rc_model.send(16'h0007, 16'h0000, 1'b0, 20'h0_0000, 3'b011, 2'b00, 9'h003,
      52'h0_0000_0000_0400, 1);
    repeat (3) @(posedge clk);
    #1 check(wr_cnt - w0, 17);
    check(last_addr, 64'h0000_0000_0000_0000);
    reg_check(PRQW_OFF_PROD, 32'h8000_0011);
    $display("test overflow done");
  endtask

  // Group responses with and without substream support, after the group is consumed
  task automatic t_resp();
    reg_write(PRQW_OFF_CTRL, 32'h0000_0003);
    reg_write(PRQW_OFF_CONS, 32'h8000_0011);
    reg_check(PRQW_OFF_STATUS, 32'h0000_0005);
    reg_write(PRQW_OFF_RESP1, 32'h000a_bcde);
    reg_write(PRQW_OFF_RESP0, 32'h91a5_1234);
    #1 check(resp_valid, 1'b1);
    check({resp_requester_id, resp_group_index, resp_success}, {16'h1234, 9'h1a5, 1'b1});
    check({resp_pasid_present, resp_pasid}, {1'b1, 20'habcde});
    @(posedge clk);
    #1 check(resp_valid, 1'b0);
    reg_write(PRQW_OFF_CTRL, 32'h0000_0001);
    reg_write(PRQW_OFF_RESP1, 32'h0001_2345);
    reg_write(PRQW_OFF_RESP0, 32'h81a5_1234);
    #1 check({resp_valid, resp_success, resp_pasid_present}, 3'b100);
    $display("test resp done");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected hundred or so cycles
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_group();
    t_codes();
    t_overflow();
    t_resp();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== rtl/prqw_msg_if.sv ====
// Purpose: Carries one incoming message and its formatted record
// Assumes: Driven and read on the same clock as the queue writer
// Notes: The formatter is purely combinational
`timescale 1ns/1ns
`default_nettype none
interface prqw_msg_if;
  import prqw_pkg::*;
  logic [15:0] requester_id;
  logic [15:0] rc_id;
  logic pasid_present;
  logic [19:0] pasid;
  logic last;
  logic write;
  logic read;
  logic exec;
  logic priv;
  logic [8:0] group_index;
  logic [51:0] page_addr;
  logic ss_support;
  logic [PRQW_REC_W-1:0] rec;
  logic is_stop;
  modport src (output requester_id, rc_id, pasid_present, pasid, last, write, read, exec,
    priv, group_index, page_addr, ss_support, input rec, is_stop);
  modport fmt (input requester_id, rc_id, pasid_present, pasid, last, write, read, exec,
    priv, group_index, page_addr, ss_support, output rec, is_stop);
endinterface
`default_nettype wire

// ==== rtl/prqw_pkg.sv ====
// Purpose: Shared constants and pointer helpers for the page request queue writer
// Assumes: 32-bit register port with byte offsets, 128-bit queue records
// Notes: Pointers hold the index plus one wrap bit just above the live index bits
package prqw_pkg;
  // Queue geometry
  localparam int PRQW_IDX_W = 19;
  localparam int PRQW_PTR_W = PRQW_IDX_W + 1;
  localparam int PRQW_REC_W = 128;
  localparam int PRQW_ENTRY_SHIFT = 4;
  localparam int PRQW_LOG2_W = 5;
  localparam logic [4:0] PRQW_LOG2_MAX = 5'h13;
  localparam logic [4:0] PRQW_LOG2_RST = 5'h04;
  // Register offsets
  localparam logic [7:0] PRQW_OFF_CTRL = 8'h00;
  localparam logic [7:0] PRQW_OFF_BASE_LO = 8'h04;
  localparam logic [7:0] PRQW_OFF_BASE_HI = 8'h08;
  localparam logic [7:0] PRQW_OFF_LOG2 = 8'h0c;
  localparam logic [7:0] PRQW_OFF_PROD = 8'h10;
  localparam logic [7:0] PRQW_OFF_CONS = 8'h14;
  localparam logic [7:0] PRQW_OFF_RESP0 = 8'h18;
  localparam logic [7:0] PRQW_OFF_RESP1 = 8'h1c;
  localparam logic [7:0] PRQW_OFF_STATUS = 8'h20;
  // Control, status and command fields
  localparam int PRQW_CTRL_EN = 0;
  localparam int PRQW_CTRL_SS = 1;
  localparam int PRQW_CTRL_IRQ = 2;
  localparam logic [2:0] PRQW_CTRL_RST = 3'h0;
  localparam int PRQW_OVF_BIT = 31;
  localparam int PRQW_RESP_GRP_LSB = 16;
  localparam int PRQW_RESP_OK = 28;
  localparam int PRQW_RESP_SSV = 31;
  // Record fields
  localparam int PRQW_REC_TAG_LSB = 32;
  localparam int PRQW_REC_PRIV = 58;
  localparam int PRQW_REC_EXEC = 59;
  localparam int PRQW_REC_LAST = 62;
  localparam int PRQW_REC_SSV = 63;
  localparam int PRQW_REC_GRP_LSB = 64;
  localparam int PRQW_REC_PA_LSB = 76;
  localparam logic [2:0] PRQW_LWR_STOP = 3'h4;

  // Wrap bit of a queue of 2^l entries
  function automatic logic [PRQW_PTR_W-1:0] prqw_wrap(input logic [4:0] l);
    return PRQW_PTR_W'(1) << l;
  endfunction

  // Mask covering index and wrap bit
  function automatic logic [PRQW_PTR_W-1:0] prqw_mask(input logic [4:0] l);
    return (prqw_wrap(l) << 1) - PRQW_PTR_W'(1);
  endfunction
endpackage

// ==== rtl/prqw_qptr.sv ====
// Purpose: Producer pointer with full and empty detection
// Assumes: Consumer pointer supplied from software register
// Notes: Pointer is index plus wrap bit, up to 2^19 entries
`timescale 1ns/1ns
`default_nettype none
module prqw_qptr import prqw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] log2_size,
  input wire logic [prqw_pkg::PRQW_PTR_W-1:0] rd_ptr,
  input wire logic advance,
  output logic [prqw_pkg::PRQW_PTR_W-1:0] wr_ptr,
  output logic full,
  output logic empty
);
  logic [PRQW_PTR_W-1:0] wr_ptr_r;
  wire [PRQW_PTR_W-1:0] diff;

  // Compare index and wrap within the live size
  assign diff = (wr_ptr_r ^ rd_ptr) & prqw_mask(log2_size);
  assign full = (diff == prqw_wrap(log2_size));
  assign empty = (diff == '0);
  assign wr_ptr = wr_ptr_r;

  // Advance by one entry per written record
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
    end else if (advance) begin
      wr_ptr_r <= (wr_ptr_r + PRQW_PTR_W'(1)) & prqw_mask(log2_size);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/prqw_rec_fmt.sv ====
// Purpose: Builds a 128-bit queue record from an incoming message
// Assumes: Record byte k sits on bits 8k+7..8k, so lane 0 is written first in memory
// Notes: Reserved fields are zero
`timescale 1ns/1ns
`default_nettype none
module prqw_rec_fmt import prqw_pkg::*; (
  prqw_msg_if.fmt m
);
  wire substream_valid_flag;

  // Substream valid only with a prefix and substream support
  assign substream_valid_flag = m.pasid_present & m.ss_support;
  // Stop marker needs a prefix, substream support and the stop code
  assign m.is_stop = substream_valid_flag & ({m.last, m.write, m.read} == PRQW_LWR_STOP);
  // Record image, low word is the source tag
  assign m.rec = {m.page_addr, 3'h0, m.group_index, substream_valid_flag, m.last, m.write, m.read,
    substream_valid_flag & m.exec, substream_valid_flag & m.priv, 6'h00, m.pasid, m.rc_id, m.requester_id};
endmodule
`default_nettype wire

// ==== rtl/prqw_top.sv ====
// Purpose: Page request queue writer, records messages into a memory ring
// Assumes: Messages and memory writes on clk; memory takes one record per cycle
// Notes: Registers on a plain strobe port, read data one cycle after the strobe
//
// What this block does
// - Records are written little-endian
// - Low 16 source tag bits are requester id
// - Substream valid follows presence of PASID prefix
// - No substream support forces substream valid low
// - Substream valid low forces execute, supervisor low
// - Record carries 20-bit context tag from PASID
// - Record holds page address and group index
// - Prefix plus code 100 with substream support is stop marker
// - Code 100 without prefix is ordinary request
// - Last flag recorded; optional pulse on last
// - Last never overtakes earlier group members
// - Group prefixes are not cross-checked
// - Response command sends group status to endpoint
// - Response carries PASID when substreams and valid
// - Accept when space, enabled, no error
// - Index arithmetic covers 2^19 entries
// - Write records only while queue enabled
// - Full on arrival toggles overflow flag once
// - Overflow active discards messages, writes nothing
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module prqw_top import prqw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic msg_valid,
  input wire logic [15:0] msg_requester_id,
  input wire logic [15:0] msg_rc_id,
  input wire logic msg_pasid_present,
  input wire logic [19:0] msg_pasid,
  input wire logic msg_last,
  input wire logic msg_write,
  input wire logic msg_read,
  input wire logic msg_exec,
  input wire logic msg_priv,
  input wire logic [8:0] msg_group_index,
  input wire logic [51:0] msg_page_addr,
  output logic mem_wr_valid,
  output logic [63:0] mem_wr_addr,
  output logic [PRQW_REC_W-1:0] mem_wr_data,
  output logic last_req_pulse,
  output logic resp_valid,
  output logic [15:0] resp_requester_id,
  output logic [8:0] resp_group_index,
  output logic resp_success,
  output logic resp_pasid_present,
  output logic [19:0] resp_pasid
);
  prqw_msg_if m ();
  logic [2:0] ctrl_r;
  logic [31:0] base_lo_r;
  logic [31:0] base_hi_r;
  logic [4:0] log2_r;
  logic [PRQW_PTR_W-1:0] rd_ptr_r;
  logic overflow_toggle_flag_r;
  logic ovack_r;
  logic [31:0] resp0_r;
  logic [19:0] resp1_r;
  logic [31:0] reg_rdata_r;
  logic mem_wr_valid_r;
  logic [63:0] mem_wr_addr_r;
  logic [PRQW_REC_W-1:0] mem_wr_data_r;
  logic last_req_pulse_r;
  logic resp_valid_r;
  logic [15:0] resp_requester_id_r;
  logic [8:0] resp_group_index_r;
  logic resp_success_r;
  logic resp_pasid_present_r;
  logic [19:0] resp_pasid_r;
  wire [PRQW_PTR_W-1:0] wr_ptr;
  wire q_full;
  wire q_empty;
  wire q_en;
  wire ss_sup;
  wire ovf_active;
  wire accept;
  wire overflow_hit;
  wire [PRQW_PTR_W-1:0] wr_idx;
  wire [63:0] entry_addr;
  wire [4:0] log2_nxt;
  wire wr_ctrl;
  wire wr_cons;
  wire wr_resp0;
  wire [31:0] rd_word;

  // Message fields into the formatter
  assign m.requester_id = msg_requester_id;
  assign m.rc_id = msg_rc_id;
  assign m.pasid_present = msg_pasid_present;
  assign m.pasid = msg_pasid;
  assign m.last = msg_last;
  assign m.write = msg_write;
  assign m.read = msg_read;
  assign m.exec = msg_exec;
  assign m.priv = msg_priv;
  assign m.group_index = msg_group_index;
  assign m.page_addr = msg_page_addr;
  assign m.ss_support = ss_sup;

  prqw_rec_fmt u_fmt (
    .m(m.fmt)
  );

  prqw_qptr u_qptr (
    .clk(clk),
    .rst(rst),
    .log2_size(log2_r),
    .rd_ptr(rd_ptr_r),
    .advance(accept),
    .wr_ptr(wr_ptr),
    .full(q_full),
    .empty(q_empty)
  );

  // Queue state and admission
  assign q_en = ctrl_r[PRQW_CTRL_EN];
  assign ss_sup = ctrl_r[PRQW_CTRL_SS];
  assign ovf_active = overflow_toggle_flag_r ^ ovack_r;
  assign accept = msg_valid & q_en & ~ovf_active & ~q_full;
  assign overflow_hit = msg_valid & q_en & q_full & ~ovf_active;
  assign wr_idx = wr_ptr & (prqw_wrap(log2_r) - PRQW_PTR_W'(1));
  assign entry_addr = {base_hi_r, base_lo_r} + (64'(wr_idx) << PRQW_ENTRY_SHIFT);

  // Register decode
  assign wr_ctrl = reg_wr & (reg_addr == PRQW_OFF_CTRL);
  assign wr_cons = reg_wr & (reg_addr == PRQW_OFF_CONS);
  assign wr_resp0 = reg_wr & (reg_addr == PRQW_OFF_RESP0);
  assign log2_nxt = (reg_wdata[4:0] > PRQW_LOG2_MAX) ? PRQW_LOG2_MAX : reg_wdata[4:0];

  // Read mux, unmapped offsets read zero
  assign rd_word =
    (reg_addr == PRQW_OFF_CTRL) ? {29'h0000_0000, ctrl_r} :
    (reg_addr == PRQW_OFF_BASE_LO) ? base_lo_r :
    (reg_addr == PRQW_OFF_BASE_HI) ? base_hi_r :
    (reg_addr == PRQW_OFF_LOG2) ? {27'h000_0000, log2_r} :
    (reg_addr == PRQW_OFF_PROD) ? {overflow_toggle_flag_r, 11'h000, wr_ptr} :
    (reg_addr == PRQW_OFF_CONS) ? {ovack_r, 11'h000, rd_ptr_r} :
    (reg_addr == PRQW_OFF_RESP0) ? resp0_r :
    (reg_addr == PRQW_OFF_RESP1) ? {12'h000, resp1_r} :
    (reg_addr == PRQW_OFF_STATUS) ? {28'h000_0000, ovf_active, q_empty, q_full, q_en} :
    32'h0000_0000;

  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= PRQW_CTRL_RST;
      base_lo_r <= 32'h0000_0000;
      base_hi_r <= 32'h0000_0000;
      log2_r <= PRQW_LOG2_RST;
    end else if (reg_wr) begin
      if (wr_ctrl) ctrl_r <= reg_wdata[2:0];
      if (reg_addr == PRQW_OFF_BASE_LO) base_lo_r <= reg_wdata;
      if (reg_addr == PRQW_OFF_BASE_HI) base_hi_r <= reg_wdata;
      if (reg_addr == PRQW_OFF_LOG2) log2_r <= log2_nxt;
    end
  end

  // Consumer pointer and overflow acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr_r <= '0;
      ovack_r <= 1'b0;
    end else if (wr_cons) begin
      rd_ptr_r <= reg_wdata[PRQW_PTR_W-1:0] & prqw_mask(log2_r);
      ovack_r <= reg_wdata[PRQW_OVF_BIT];
    end
  end

  // Overflow flag toggles once per overflow episode
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_toggle_flag_r <= 1'b0;
    end else if (overflow_hit) begin
      overflow_toggle_flag_r <= ~overflow_toggle_flag_r;
    end
  end

  // Record write in arrival order, last never ahead of its group
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr_valid_r <= 1'b0;
      mem_wr_addr_r <= 64'h0000_0000_0000_0000;
      mem_wr_data_r <= '0;
      last_req_pulse_r <= 1'b0;
    end else begin
      mem_wr_valid_r <= accept;
      last_req_pulse_r <= accept & msg_last & ~m.is_stop & ctrl_r[PRQW_CTRL_IRQ];
      if (accept) begin
        mem_wr_addr_r <= entry_addr;
        mem_wr_data_r <= m.rec;
      end
    end
  end

  // Group response command
  always_ff @(posedge clk) begin
    if (rst) begin
      resp0_r <= 32'h0000_0000;
      resp1_r <= 20'h0_0000;
      resp_valid_r <= 1'b0;
      resp_requester_id_r <= 16'h0000;
      resp_group_index_r <= 9'h000;
      resp_success_r <= 1'b0;
      resp_pasid_present_r <= 1'b0;
      resp_pasid_r <= 20'h0_0000;
    end else begin
      resp_valid_r <= wr_resp0;
      if (reg_wr && reg_addr == PRQW_OFF_RESP1) resp1_r <= reg_wdata[19:0];
      if (wr_resp0) begin
        resp0_r <= reg_wdata;
        resp_requester_id_r <= reg_wdata[15:0];
        resp_group_index_r <= reg_wdata[PRQW_RESP_GRP_LSB +: 9];
        resp_success_r <= reg_wdata[PRQW_RESP_OK];
        resp_pasid_present_r <= ss_sup & reg_wdata[PRQW_RESP_SSV];
        resp_pasid_r <= resp1_r;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      reg_rdata_r <= reg_rd ? rd_word : 32'h0000_0000;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = reg_rdata_r;
  assign mem_wr_valid = mem_wr_valid_r;
  assign mem_wr_addr = mem_wr_addr_r;
  assign mem_wr_data = mem_wr_data_r;
  assign last_req_pulse = last_req_pulse_r;
  assign resp_valid = resp_valid_r;
  assign resp_requester_id = resp_requester_id_r;
  assign resp_group_index = resp_group_index_r;
  assign resp_success = resp_success_r;
  assign resp_pasid_present = resp_pasid_present_r;
  assign resp_pasid = resp_pasid_r;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_src_tag;
    accept |=> mem_wr_valid && mem_wr_data[15:0] == $past(msg_requester_id)
      && mem_wr_data[PRQW_REC_PA_LSB +: 52] == $past(msg_page_addr);
  endproperty
  a_src_tag: assert property (p_src_tag) else $error("record tag or address wrong");

  property p_ssv;
    accept |=> mem_wr_data[PRQW_REC_SSV] == $past(msg_pasid_present & ss_sup);
  endproperty
  a_ssv: assert property (p_ssv) else $error("substream valid wrong");

  property p_perm_zero;
    mem_wr_valid && !mem_wr_data[PRQW_REC_SSV]
      |-> !mem_wr_data[PRQW_REC_EXEC] && !mem_wr_data[PRQW_REC_PRIV];
  endproperty
  a_perm_zero: assert property (p_perm_zero) else $error("permissions without substream");

  property p_tag_grp;
    accept |=> mem_wr_data[PRQW_REC_TAG_LSB +: 20] == $past(msg_pasid)
      && mem_wr_data[PRQW_REC_GRP_LSB +: 9] == $past(msg_group_index)
      && mem_wr_data[PRQW_REC_LAST] == $past(msg_last);
  endproperty
  a_tag_grp: assert property (p_tag_grp) else $error("context tag or group wrong");

  property p_disabled;
    !q_en |=> !mem_wr_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("write while disabled");

  property p_accept;
    msg_valid && q_en && !ovf_active && !q_full |=> mem_wr_valid
      && mem_wr_addr == $past(entry_addr);
  endproperty
  a_accept: assert property (p_accept) else $error("free entry not used");

  property p_ovf_enter;
    msg_valid && q_en && q_full && !ovf_active |=> ovf_active && !mem_wr_valid;
  endproperty
  a_ovf_enter: assert property (p_ovf_enter) else $error("overflow not entered");

  property p_ovf_drop;
    ovf_active |=> !mem_wr_valid && $stable(overflow_toggle_flag_r);
  endproperty
  a_ovf_drop: assert property (p_ovf_drop) else $error("write during overflow");

  property p_last_pulse;
    accept && msg_last && !m.is_stop && ctrl_r[PRQW_CTRL_IRQ] |=> last_req_pulse;
  endproperty
  a_last_pulse: assert property (p_last_pulse) else $error("last pulse missing");

  property p_resp;
    wr_resp0 |=> resp_valid && resp_pasid_present == $past(ss_sup & reg_wdata[PRQW_RESP_SSV])
      ##1 resp_valid == $past(wr_resp0);
  endproperty
  a_resp: assert property (p_resp) else $error("response wrong");

  // Stop markers, plain codes, permissions and held response fields
  property p_stop;
    accept && m.is_stop |=> mem_wr_data[PRQW_REC_SSV] && !last_req_pulse;
  endproperty
  a_stop: assert property (p_stop) else $error("stop marker recorded wrongly");

  property p_plain_code;
    accept && !msg_pasid_present |=> !mem_wr_data[PRQW_REC_SSV];
  endproperty
  a_plain_code: assert property (p_plain_code) else $error("plain request has substream");

  property p_perm_keep;
    accept && msg_pasid_present && ss_sup |=> mem_wr_data[PRQW_REC_EXEC] == $past(msg_exec)
      && mem_wr_data[PRQW_REC_PRIV] == $past(msg_priv);
  endproperty
  a_perm_keep: assert property (p_perm_keep) else $error("permissions lost");

  property p_full_hold;
    q_full |=> !mem_wr_valid;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("write into full queue");

  property p_resp_hold;
    !wr_resp0 |=> $stable(resp_group_index) && $stable(resp_success);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response fields moved");

  cover property (accept && msg_last);
  cover property (overflow_hit);
  cover property (accept && m.is_stop);
  cover property (wr_resp0 && ss_sup);
endmodule
`default_nettype wire
